// File: core/fpsr_pkg.sv
package fpsr_pkg;

  // ==========================================================================
  // clocking
  // ==========================================================================
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned TICK_HZ       = 90_000;
  localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
  localparam int unsigned TICKS_PER_MS  = TICK_HZ / 1000;
  localparam int unsigned PWM_STEPS     = 255;

  // ==========================================================================
  // register offsets
  // ==========================================================================
  localparam logic [7:0] ADDR_RAMP_RATE_A  = 8'h62;
  localparam logic [7:0] ADDR_RAMP_RATE_B  = 8'h63;
  localparam logic [7:0] ADDR_MON_CONFIG   = 8'h7F;
  localparam logic [7:0] ADDR_PWM_OPTIONS1 = 8'h94;
  localparam logic [7:0] ADDR_PWM_OPTIONS2 = 8'h95;
  localparam logic [7:0] ADDR_PWM_OPTIONS3 = 8'h96;

  // ==========================================================================
  // field positions and reset values
  // ==========================================================================
  localparam int unsigned RRA_SEL0_LSB     = 0;
  localparam int unsigned RRA_SEL1_LSB     = 4;
  localparam int unsigned RRB_SEL2_LSB     = 0;
  localparam int unsigned RRB_ENABLE_LSB   = 4;
  localparam int unsigned CFG_SPIN_UP_REDUCTION_ENABLE_BIT    = 4;
  localparam int unsigned OPT_RTO_BIT      = 0;
  localparam logic [7:0]  RST_RAMP_RATE_A  = 8'h00;
  localparam logic [7:0]  RST_RAMP_RATE_B  = 8'h00;
  localparam logic [7:0]  RST_MON_CONFIG   = 8'h10;
  localparam logic [7:0]  RST_PWM_OPTIONS  = 8'h00;

  // ==========================================================================
  // duty values
  // ==========================================================================
  localparam logic [7:0] DUTY_OFF  = 8'h00;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_50   = 8'h80;
  localparam logic [7:0] DUTY_60   = 8'h99;
  localparam logic [7:0] DUTY_70   = 8'hB3;

  // ==========================================================================
  // ramp step times in msec, indexed by ramp_rate_select
  // ==========================================================================
  localparam logic [7:0] STEP_MS [8] = '{8'd206, 8'd104, 8'd69, 8'd41,
                                         8'd26, 8'd18, 8'd10, 8'd5};
  localparam int unsigned SPIN_UNIT_MS = 250;

endpackage : fpsr_pkg

// File: core/fpsr_top.sv
`timescale 1ns/1ps

module fpsr_top
  import fpsr_pkg::*;
#(
  parameter int unsigned N_PWM = 3
)(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  // register port
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  input  wire logic                 reg_wr_in,
  output logic      [7:0]           reg_rdata_out,
  // fan algorithm and tachometer side
  input  wire logic [N_PWM*8-1:0]   calc_duty_in,
  input  wire logic [N_PWM*16-1:0]  tach_count_in,
  input  wire logic [N_PWM*16-1:0]  tach_min_in,
  input  wire logic [N_PWM*N_PWM-1:0] tach_assoc_in,
  input  wire logic [N_PWM*3-1:0]   spin_time_sel_in,
  input  wire logic [N_PWM-1:0]     forced_spinup_enable_in,
  input  wire logic [N_PWM-1:0]     spinup_fail_clear_in,
  // power control
  input  wire logic                 power_good_input_in,
  input  wire logic                 start_bit_in,
  input  wire logic [1:0]           startup_duty_sel_in,
  // outputs
  output logic [N_PWM-1:0]          pwm_out,
  output logic [N_PWM*8-1:0]        current_duty_out,
  output logic [N_PWM*16-1:0]       tach_reading_out,
  output logic [N_PWM-1:0]          spinup_fail_status_out,
  output logic [N_PWM-1:0]          spinup_active_out
);

  // ==========================================================================
  // reset release
  // ==========================================================================
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================================================
  // 90kHz tick, msec enable and pwm period counter
  // ==========================================================================
  logic [7:0] tick_cnt_r, tick_cnt_nxt;
  logic       tick;
  logic [6:0] ms_cnt_r, ms_cnt_nxt;
  logic       ms_tick;
  logic [7:0] pwm_cnt_r, pwm_cnt_nxt;
  logic       period_start;

  always_comb
  begin
    tick         = (tick_cnt_r == 8'(TICK_DIV - 1));
    tick_cnt_nxt = tick ? 8'h00 : tick_cnt_r + 8'h01;
    ms_tick      = tick && (ms_cnt_r == 7'(TICKS_PER_MS - 1));
    ms_cnt_nxt   = ms_cnt_r;
    pwm_cnt_nxt  = pwm_cnt_r;
    period_start = tick && (pwm_cnt_r == 8'(PWM_STEPS - 1));
    if (tick)
    begin
      ms_cnt_nxt  = ms_tick ? 7'h00 : ms_cnt_r + 7'h01;
      pwm_cnt_nxt = period_start ? 8'h00 : pwm_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      tick_cnt_r <= 8'h00;
      ms_cnt_r   <= 7'h00;
      pwm_cnt_r  <= 8'h00;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
      ms_cnt_r   <= ms_cnt_nxt;
      pwm_cnt_r  <= pwm_cnt_nxt;
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  logic [7:0] rr_a_r, rr_a_nxt;
  logic [7:0] rr_b_r, rr_b_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] opt_r [N_PWM];
  logic [7:0] opt_nxt [N_PWM];
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rr_a_nxt  = rr_a_r;
    rr_b_nxt  = rr_b_r;
    cfg_nxt   = cfg_r;
    for (int i = 0; i < N_PWM; i++)
      opt_nxt[i] = opt_r[i];
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        ADDR_RAMP_RATE_A:  rr_a_nxt = reg_wdata_in;
        ADDR_RAMP_RATE_B:  rr_b_nxt = reg_wdata_in;
        ADDR_MON_CONFIG:   cfg_nxt = reg_wdata_in;
        ADDR_PWM_OPTIONS1: opt_nxt[0] = reg_wdata_in;
        ADDR_PWM_OPTIONS2: opt_nxt[1] = reg_wdata_in;
        ADDR_PWM_OPTIONS3: opt_nxt[2] = reg_wdata_in;
        default:           ;
      endcase
    end
    unique case (reg_addr_in)
      ADDR_RAMP_RATE_A:  rdata_nxt = rr_a_r;
      ADDR_RAMP_RATE_B:  rdata_nxt = rr_b_r;
      ADDR_MON_CONFIG:   rdata_nxt = cfg_r;
      ADDR_PWM_OPTIONS1: rdata_nxt = opt_r[0];
      ADDR_PWM_OPTIONS2: rdata_nxt = opt_r[1];
      ADDR_PWM_OPTIONS3: rdata_nxt = opt_r[2];
      default:           rdata_nxt = 8'h00;
    endcase
  end

  // ==========================================================================
  // per-output duty, ramp and spin-up state
  // ==========================================================================
  logic [7:0]  calc_prev_r [N_PWM];
  logic [7:0]  ramp_r      [N_PWM];
  logic [7:0]  ramp_nxt    [N_PWM];
  logic [7:0]  out_r       [N_PWM];
  logic [7:0]  out_nxt     [N_PWM];
  logic [7:0]  step_ms_r   [N_PWM];
  logic [7:0]  step_ms_nxt [N_PWM];
  logic [11:0] spin_ms_r   [N_PWM];
  logic [11:0] spin_ms_nxt [N_PWM];
  logic [N_PWM-1:0] spin_r, spin_nxt;
  logic [N_PWM-1:0] fail_r, fail_nxt;
  logic [N_PWM-1:0] pin_nxt;
  logic [N_PWM*8-1:0] duty_rd_nxt;
  logic        pg_prev_r;
  logic [7:0]  start_duty;

  always_comb
  begin
    logic [7:0]  calc;
    logic [2:0]  rsel;
    logic [7:0]  step_lim;
    logic [11:0] spin_lim;
    logic        ramp_en;
    logic        rise;
    logic        step;
    logic        tach_ok;
    logic        expire;
    logic        fail_set;
    calc     = 8'h00;
    rsel     = 3'b000;
    step_lim = 8'h00;
    spin_lim = 12'h000;
    ramp_en  = 1'b0;
    rise     = 1'b0;
    step     = 1'b0;
    tach_ok  = 1'b0;
    expire   = 1'b0;
    fail_set = 1'b0;
    unique case (startup_duty_sel_in)
      2'b00:   start_duty = DUTY_50;
      2'b01:   start_duty = DUTY_60;
      2'b10:   start_duty = DUTY_70;
      default: start_duty = DUTY_FULL;
    endcase
    for (int i = 0; i < N_PWM; i++)
    begin
      calc = calc_duty_in[i*8 +: 8];
      unique case (i)
        0:       rsel = rr_a_r[RRA_SEL0_LSB +: 3];
        1:       rsel = rr_a_r[RRA_SEL1_LSB +: 3];
        default: rsel = rr_b_r[RRB_SEL2_LSB +: 3];
      endcase
      step_lim = STEP_MS[rsel];
      ramp_en  = rr_b_r[RRB_ENABLE_LSB + i];
      rise     = (calc != DUTY_OFF) && (calc_prev_r[i] == DUTY_OFF);
      // ramp step timer, restarted on turn-on
      step_ms_nxt[i] = step_ms_r[i];
      step = 1'b0;
      if (rise)
        step_ms_nxt[i] = 8'h00;
      else if (ms_tick)
      begin
        step = (step_ms_r[i] + 8'h01 >= step_lim);
        step_ms_nxt[i] = step ? 8'h00 : step_ms_r[i] + 8'h01;
      end
      // internal ramp duty
      ramp_nxt[i] = ramp_r[i];
      if (!ramp_en)
        ramp_nxt[i] = calc;
      else if (rise)
        ramp_nxt[i] = calc;
      else if ((calc == DUTY_OFF) && !opt_r[i][OPT_RTO_BIT])
        ramp_nxt[i] = DUTY_OFF;
      else if (step && (ramp_r[i] < calc))
        ramp_nxt[i] = ramp_r[i] + 8'h01;
      else if (step && (ramp_r[i] > calc))
        ramp_nxt[i] = ramp_r[i] - 8'h01;
      // output duty latched at period start (loaded with calc at once on a ramped turn-on), so slow periods jump
      out_nxt[i] = out_r[i];
      if (rise && ramp_en)
        out_nxt[i] = calc;
      else if (period_start)
        out_nxt[i] = ramp_r[i];
      // tachometer validity over all associated tachs
      tach_ok = 1'b1;
      for (int t = 0; t < N_PWM; t++)
        if (tach_assoc_in[i*N_PWM + t]
            && !(tach_count_in[t*16 +: 16] < tach_min_in[t*16 +: 16]))
          tach_ok = 1'b0;
      if (tach_assoc_in[i*N_PWM +: N_PWM] == '0)
        tach_ok = 1'b0;
      // spin-up timer
      spin_lim = 12'((spin_time_sel_in[i*3 +: 3] + 1) * SPIN_UNIT_MS);
      spin_nxt[i]    = spin_r[i];
      spin_ms_nxt[i] = spin_ms_r[i];
      expire   = 1'b0;
      fail_set = 1'b0;
      if ((rise && (out_r[i] == DUTY_OFF))
          || (power_good_input_in && !pg_prev_r && forced_spinup_enable_in[i]))
      begin
        spin_nxt[i]    = 1'b1;
        spin_ms_nxt[i] = 12'h000;
      end
      else if (spin_r[i])
      begin
        if (ms_tick)
        begin
          expire = (spin_ms_r[i] + 12'h001 >= spin_lim);
          spin_ms_nxt[i] = spin_ms_r[i] + 12'h001;
        end
        if (cfg_r[CFG_SPIN_UP_REDUCTION_ENABLE_BIT] && tach_ok)
          spin_nxt[i] = 1'b0;
        else if (expire)
        begin
          spin_nxt[i] = 1'b0;
          fail_set    = 1'b1;
        end
      end
      fail_nxt[i] = fail_set | (fail_r[i] & ~spinup_fail_clear_in[i]);
      // pin level
      if (!power_good_input_in)
        pin_nxt[i] = 1'b0;
      else if (!start_bit_in)
        pin_nxt[i] = (pwm_cnt_r < start_duty) || (start_duty == DUTY_FULL);
      else if (spin_r[i])
        pin_nxt[i] = 1'b1;
      else
        pin_nxt[i] = (pwm_cnt_r < out_r[i]) || (out_r[i] == DUTY_FULL);
      duty_rd_nxt[i*8 +: 8] = spin_nxt[i] ? DUTY_OFF : out_r[i];
    end
  end

  // ==========================================================================
  // state registers
  // ==========================================================================
  always_ff @(posedge clk_in or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      rr_a_r                 <= RST_RAMP_RATE_A;
      rr_b_r                 <= RST_RAMP_RATE_B;
      cfg_r                  <= RST_MON_CONFIG;
      reg_rdata_out          <= 8'h00;
      pg_prev_r              <= 1'b1;  // no false power-good edge out of reset
      spin_r                 <= '0;
      fail_r                 <= '0;
      pwm_out                <= '0;
      current_duty_out       <= '0;
      tach_reading_out       <= '0;
      spinup_fail_status_out <= '0;
      spinup_active_out      <= '0;
      for (int i = 0; i < N_PWM; i++)
      begin
        opt_r[i]       <= RST_PWM_OPTIONS;
        calc_prev_r[i] <= DUTY_OFF;
        ramp_r[i]      <= DUTY_OFF;
        out_r[i]       <= DUTY_OFF;
        step_ms_r[i]   <= 8'h00;
        spin_ms_r[i]   <= 12'h000;
      end
    end
    else
    begin
      rr_a_r                 <= rr_a_nxt;
      rr_b_r                 <= rr_b_nxt;
      cfg_r                  <= cfg_nxt;
      reg_rdata_out          <= rdata_nxt;
      pg_prev_r              <= power_good_input_in;
      spin_r                 <= spin_nxt;
      fail_r                 <= fail_nxt;
      pwm_out                <= pin_nxt;
      current_duty_out       <= duty_rd_nxt;
      tach_reading_out       <= tach_count_in;
      spinup_fail_status_out <= fail_nxt;
      spinup_active_out      <= spin_nxt;
      for (int i = 0; i < N_PWM; i++)
      begin
        opt_r[i]       <= opt_nxt[i];
        calc_prev_r[i] <= calc_duty_in[i*8 +: 8];
        ramp_r[i]      <= ramp_nxt[i];
        out_r[i]       <= out_nxt[i];
        step_ms_r[i]   <= step_ms_nxt[i];
        spin_ms_r[i]   <= spin_ms_nxt[i];
      end
    end
  end

endmodule : fpsr_top

// File: verification/fpsr_fan_model.sv
`timescale 1ns/1ps

module fpsr_fan_model #(
  parameter int SPIN_CLKS = 40
)(
  input  wire logic        clk_in,
  input  wire logic        pwm_in,
  output logic      [15:0] tach_out
);
  int run_r = 0;

  // rotor gains speed only while driven, then coasts; a stopped fan reads full scale
  always @(posedge clk_in)
    if (pwm_in && run_r < SPIN_CLKS)
      run_r <= run_r + 1;
  assign tach_out = (run_r >= SPIN_CLKS) ? 16'h0400 : 16'hFFFF;
endmodule : fpsr_fan_model

// File: verification/fpsr_top_properties.sv
`timescale 1ns/1ps

module fpsr_top_properties
  import fpsr_pkg::*;
#(
  parameter int unsigned N_PWM = 3
)(
  input wire logic                 clk_in,
  input wire logic                 rst_b_in,
  input wire logic [7:0]           reg_addr_in,
  input wire logic [7:0]           reg_wdata_in,
  input wire logic                 reg_wr_in,
  input wire logic [7:0]           reg_rdata_out,
  input wire logic [N_PWM*8-1:0]   calc_duty_in,
  input wire logic [N_PWM*16-1:0]  tach_count_in,
  input wire logic [N_PWM*16-1:0]  tach_min_in,
  input wire logic [N_PWM*N_PWM-1:0] tach_assoc_in,
  input wire logic                 power_good_input_in,
  input wire logic                 start_bit_in,
  input wire logic [1:0]           startup_duty_sel_in,
  input wire logic [N_PWM-1:0]     pwm_out,
  input wire logic [N_PWM*8-1:0]   current_duty_out,
  input wire logic [N_PWM*16-1:0]  tach_reading_out,
  input wire logic [N_PWM-1:0]     spinup_fail_status_out,
  input wire logic [N_PWM-1:0]     spinup_active_out
);
  import fpsr_pkg::*;
  // ==========================================================================
  // helpers
  // ==========================================================================
  logic [2:0] up_r, up_nxt;
  logic       spin_up_reduction_enable_r, spin_up_reduction_enable_nxt, live, ok0, unmapped;

  assign live = (up_r == 3'h7);
  assign unmapped = !(reg_addr_in inside {ADDR_RAMP_RATE_A, ADDR_RAMP_RATE_B, ADDR_MON_CONFIG,
                      ADDR_PWM_OPTIONS1, ADDR_PWM_OPTIONS2, ADDR_PWM_OPTIONS3});
  always_comb
  begin
    up_nxt = live ? up_r : up_r + 3'h1;
    spin_up_reduction_enable_nxt = (reg_wr_in && reg_addr_in == ADDR_MON_CONFIG) ? reg_wdata_in[CFG_SPIN_UP_REDUCTION_ENABLE_BIT]
                                                               : spin_up_reduction_enable_r;
    ok0 = |tach_assoc_in[N_PWM-1:0];
    for (int t = 0; t < N_PWM; t++)
      if (tach_assoc_in[t] && tach_count_in[t*16+:16] >= tach_min_in[t*16+:16])
        ok0 = 1'b0;
  end
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      up_r    <= 3'h0;
      spin_up_reduction_enable_r <= 1'b1;
    end
    else
    begin
      up_r    <= up_nxt;
      spin_up_reduction_enable_r <= spin_up_reduction_enable_nxt;
    end

  // ==========================================================================
  // properties
  // ==========================================================================
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_spin_start;
    live && calc_duty_in[7:0] != 8'h00 && $past(calc_duty_in[7:0]) == 8'h00
      && current_duty_out[7:0] == 8'h00 && !(spin_up_reduction_enable_r && ok0)
      && power_good_input_in && start_bit_in;
  endsequence
  sequence s_spinning;
    spinup_active_out[0] && $past(spinup_active_out[0]);
  endsequence

  spin_start_a: assert property (s_spin_start |-> ##[1:2] spinup_active_out[0])
    else $error("spin-up did not start");
  spin_pin_full_a: assert property (s_spinning ##0 (power_good_input_in && start_bit_in
    && $past(power_good_input_in && start_bit_in)) |-> pwm_out[0])
    else $error("pin not full during spin-up");
  spin_duty_zero_a: assert property (spinup_active_out[0]
    |-> current_duty_out[7:0] == 8'h00)
    else $error("duty not reported zero during spin-up");
  early_end_a: assert property (spinup_active_out[0] && spin_up_reduction_enable_r && ok0
    |-> ##[1:3] !spinup_active_out[0])
    else $error("spin-up not cut short by tach");
  fail_expiry_a: assert property ($rose(spinup_fail_status_out[0])
    |-> $past(spinup_active_out[0]) && !spinup_active_out[0])
    else $error("fail status outside expiry");
  full_start_a: assert property ((live && power_good_input_in && !start_bit_in
    && startup_duty_sel_in == 2'h3) [*3] |-> &pwm_out)
    else $error("startup duty not full");
  tach_echo_a: assert property (live |-> tach_reading_out == $past(tach_count_in))
    else $error("tach reading differs");
  cfg_read_a: assert property (live && $past(reg_addr_in) == ADDR_MON_CONFIG
    && !$past(reg_wr_in) && !$past(reg_wr_in, 2) && !$past(reg_wr_in, 3)
    |-> reg_rdata_out[CFG_SPIN_UP_REDUCTION_ENABLE_BIT] == $past(spin_up_reduction_enable_r))
    else $error("reduction bit reads wrong");
  unmapped_read_a: assert property (live && $past(unmapped) && $past(unmapped, 2)
    |-> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule : fpsr_top_properties

bind fpsr_top fpsr_top_properties #(.N_PWM(N_PWM)) u_fpsr_top_properties (.*);

// File: verification/tb_fpsr_top.sv
`timescale 1ns/1ps

module tb_fpsr_top;
  import fpsr_pkg::*;
  typedef struct {int id; logic [23:0] e;} fpsr_note_s;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end

  logic        clk_in = 0, rst_b_in = 0, reg_wr_in = 0, power_good_input_in = 1, start_bit_in = 1;
  logic [7:0]  reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out;
  logic [23:0] calc_duty_in = 0, current_duty_out;
  logic [47:0] tach_count_in, tach_reading_out;
  logic [47:0] tach_min_in = {3{16'h1000}};
  logic [8:0]  tach_assoc_in = 9'b100_110_001, spin_time_sel_in = 0;
  logic [2:0]  pwm_out, spinup_fail_status_out, spinup_active_out;
  logic [2:0]  forced_spinup_enable_in = 0, spinup_fail_clear_in = 0;
  logic [1:0]  startup_duty_sel_in = 0;
  logic [7:0]  v;
  int          bad_count = 0, tests_run = 0;
  fpsr_note_s  q[$];
  string       nm [6] = '{"rdata", "spin_active", "pwm", "duty", "fail", "tach_rd0"};
  logic [7:0]  ra [6] = '{8'h62, 8'h63, 8'h7F, 8'h94, 8'h96, 8'h40};
  logic [7:0]  rv [6] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};

  always #25 clk_in = ~clk_in;

  fpsr_top u_fpsr_top (.*);
  for (genvar i = 0; i < 3; i++)
  begin : g_fan
    fpsr_fan_model u_fpsr_fan_model (.clk_in(clk_in), .pwm_in(pwm_out[i]),
                                     .tach_out(tach_count_in[i*16+:16]));
  end

  function automatic logic [23:0] obs(input int id);
    case (id)
      0: return {16'h0, reg_rdata_out};
      1: return {21'h0, spinup_active_out};
      2: return {21'h0, pwm_out};
      3: return current_duty_out;
      4: return {21'h0, spinup_fail_status_out};
      default: return {8'h0, tach_reading_out[15:0]};
    endcase
  endfunction : obs

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick
  task automatic chk(input int id, input logic [23:0] e);
    q.push_back('{id, e});
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1;
    tick(1);
    reg_wr_in = 0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_in = a;
    tick(2);
    chk(0, {16'h0, e});
  endtask : rd
  task automatic test_done;
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // results settle well before the next rising edge
  always @(negedge clk_in)
  begin
    #2;
    while (q.size() > 0)
    begin
      `CHK(nm[q[0].id], q[0].e, obs(q[0].id))
      void'(q.pop_front());
    end
  end

  initial
  begin
    #4_000_000;
    bad_count++;
    test_done;
  end

  initial
  begin
    v = 8'($urandom(65920));
    tick(5);
    rst_b_in = 1;
    tick(4);
    for (int k = 0; k < 6; k++)
      rd(ra[k], rv[k]);
    v = 8'($urandom);
    wr(ADDR_RAMP_RATE_A, v);
    rd(ADDR_RAMP_RATE_A, v);
    wr(8'h33, 8'hA5);
    rd(8'h33, 8'h00);
    start_bit_in = 0;
    startup_duty_sel_in = 2'h3;
    tick(3);
    chk(2, 24'h7);
    power_good_input_in = 0;
    tick(3);
    chk(2, 24'h0);
    power_good_input_in = 1;
    start_bit_in = 1;
    forced_spinup_enable_in = 3'h1;
    tick(3);
    chk(1, 24'h1);
    chk(2, 24'h1);
    v = 8'($urandom_range(255, 1));
    calc_duty_in[15:0] = {v, 8'h80};
    tick(3);
    chk(1, 24'h3);
    chk(2, 24'h3);
    chk(3, 24'h0);
    chk(5, 24'hFFFF);
    tick(60);
    chk(1, 24'h2);
    chk(5, 24'h0400);
    wr(ADDR_MON_CONFIG, 8'h00);
    wr(ADDR_RAMP_RATE_B, 8'h40);
    rd(ADDR_RAMP_RATE_B, 8'h40);
    calc_duty_in[23:16] = 8'h40;
    tick(60);
    chk(1, 24'h6);
    wr(ADDR_MON_CONFIG, 8'h10);
    tick(3);
    chk(1, 24'h0);
    for (int k = 0; k < 60000 && current_duty_out[7:0] === 8'h00; k++)
      tick(1);
    tick(2);
    chk(3, {8'h40, v, 8'h80});
    chk(4, 24'h0);
    tick(1);
    test_done;
  end
endmodule : tb_fpsr_top
